// ---- ufb_pkg.sv ----
// constants, offsets and field layout of the uart fifo/irq/baud core
package ufb_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_DATA    = 5'h00;
  localparam logic [4:0] OFF_IER     = 5'h04;
  localparam logic [4:0] OFF_IDENT   = 5'h08;
  localparam logic [4:0] OFF_SCRATCH = 5'h1C;
  localparam int unsigned FC_FIFO_EN = 0;
  localparam int unsigned FC_RX_RST  = 1;
  localparam int unsigned FC_TX_RST  = 2;
  localparam int unsigned FC_DMA     = 3;
  localparam int unsigned FC_TRIG    = 6;
  localparam int unsigned IE_RX = 0;
  localparam int unsigned IE_TX = 1;
  localparam int unsigned IE_LS = 2;
  localparam int unsigned IE_HS = 3;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_RLS  = 4'h6;
  localparam logic [3:0] ID_RDA  = 4'h4;
  localparam logic [3:0] ID_TOUT = 4'hC;
  localparam logic [3:0] ID_THRE = 4'h2;
  localparam logic [3:0] ID_MSR  = 4'h0;
  localparam logic [7:0]  IER_RST = 8'h00;
  localparam logic [7:0]  SCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reference from which the normal-mode base rate is cut
  localparam int unsigned REF_HZ       = 24_000_000;
  localparam int unsigned NORM_HZ_D100 = 18461;
  localparam int unsigned PRE_DIV_INT  = (REF_HZ / 100) / NORM_HZ_D100;
  localparam logic [3:0]  PRE_DIV      = PRE_DIV_INT[3:0];
  localparam int unsigned TOUT_CHARS    = 4;
  localparam int unsigned BITS_PER_CHAR = 10;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned TOUT_INT      = TOUT_CHARS * BITS_PER_CHAR * TICKS_PER_BIT;
  localparam logic [9:0]  TOUT_TICKS    = TOUT_INT[9:0];
endpackage

// ---- ufb_baud_if.sv ----
// link between register logic and the baud rate generator
`timescale 1ns/1ps
`default_nettype none
interface ufb_baud_if;
  logic [15:0] divisor;
  logic        high_speed;
  logic        reload;
  logic        tick16;
  modport ctrl (output divisor, output high_speed, output reload, input tick16);
  modport gen  (input divisor, input high_speed, input reload, output tick16);
endinterface
`default_nettype wire

// ---- ufb_baud_gen.sv ----
// programmable baud generator producing the 16x tick
`timescale 1ns/1ps
`default_nettype none
module ufb_baud_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  ufb_baud_if.gen   bif
);
  import ufb_pkg::*;
  logic [3:0]  pre_r;
  logic [15:0] cnt_r;
  logic        tick_r;
  logic        step;
  logic [15:0] div_eff;

  // a zero divisor is taken as one rather than stalling the line
  assign div_eff = (bif.divisor == 16'h0000) ? 16'h0001 : bif.divisor;
  assign step    = bif.high_speed || (pre_r == PRE_DIV - 4'h1);
  assign bif.tick16 = tick_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_r  <= 4'h0;
      cnt_r  <= 16'h0001;
      tick_r <= 1'b0;
    end
    else if (bif.reload)
    begin
      pre_r  <= 4'h0;
      cnt_r  <= div_eff;
      tick_r <= 1'b0;
    end
    else
    begin
      pre_r  <= step ? 4'h0 : pre_r + 4'h1;
      tick_r <= step && (cnt_r <= 16'h0001);
      if (step)
      begin
        cnt_r <= (cnt_r <= 16'h0001) ? div_eff : cnt_r - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ufb_core.sv ----
// uart fifo control, interrupt identification, enables, divisor and scratch
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ufb_core (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [ufb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [ufb_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  input  wire logic                       divisor_access,
  input  wire logic                       high_speed,
  input  wire logic                       line_err,
  input  wire logic [4:0]                 rx_count,
  input  wire logic                       rx_push,
  input  wire logic                       rx_read,
  input  wire logic                       tx_empty,
  input  wire logic                       tx_write,
  input  wire logic                       modem_change,
  output logic                            fifo_mode,
  output logic                            dma_mode1,
  output logic [1:0]                      rx_trig_sel,
  output logic                            tx_fifo_rst,
  output logic                            rx_fifo_rst,
  output logic                            baud_tick16,
  output logic                            irq_out
);
  import ufb_pkg::*;

  ufb_baud_if bif ();

  logic        awready_r;
  logic        aw_held_r;
  logic [4:0]  awaddr_r;
  logic        wready_r;
  logic        w_held_r;
  logic [7:0]  wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        fifo_en_r;
  logic        dma_sel_r;
  logic [1:0]  trig_r;
  logic        tx_rst_r;
  logic        rx_rst_r;
  logic [7:0]  ier_r;
  logic [15:0] div_r;
  logic        reload_r;
  logic [7:0]  scr_r;
  logic        thre_r;
  logic        tx_empty_d_r;
  logic [9:0]  tout_cnt_r;
  logic        irq_r;
  logic        tick_r;
  logic        rd_ident_r;
  logic        rd_ier_r;

  logic        do_wr;
  logic        wr_ok;
  logic        ar_hs;
  logic [7:0]  rd_val;
  logic        rd_err;
  logic [4:0]  trig_lvl;
  logic        tout_hit;
  logic        thre_set;
  logic        thre_clr;
  logic        src_rls;
  logic        src_rda;
  logic        src_tout;
  logic        src_thre;
  logic        src_ms;
  logic [3:0]  id_code;
  logic [7:0]  ident_val;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign fifo_mode     = fifo_en_r;
  assign dma_mode1     = dma_sel_r;
  assign rx_trig_sel   = trig_r;
  assign tx_fifo_rst   = tx_rst_r;
  assign rx_fifo_rst   = rx_rst_r;
  assign baud_tick16   = tick_r;
  assign irq_out       = irq_r;

  assign bif.divisor    = div_r;
  assign bif.high_speed = high_speed;
  assign bif.reload     = reload_r;

  ufb_baud_gen u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bif     (bif.gen)
  );

  // write address and data may arrive in either order; both are held
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok = do_wr && wstrb0_r;
  assign ar_hs = s_axi_arvalid && arready_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
      awaddr_r  <= 5'h00;
    end
    else if (s_axi_awvalid && awready_r)
    begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end
    else if (s_axi_wvalid && wready_r)
    begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end
    else if (bvalid_r && s_axi_bready)
    begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      case (awaddr_r)
        OFF_DATA, OFF_IER, OFF_IDENT, OFF_SCRATCH: bresp_r <= RESP_OKAY;
        default:                                   bresp_r <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // fifo control: other bits only take effect while enable is written as 1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_en_r <= 1'b0;
      dma_sel_r <= 1'b0;
      trig_r    <= 2'h0;
      tx_rst_r  <= 1'b0;
      rx_rst_r  <= 1'b0;
    end
    else if (wr_ok && awaddr_r == OFF_IDENT)
    begin
      fifo_en_r <= wdata_r[FC_FIFO_EN];
      dma_sel_r <= wdata_r[FC_FIFO_EN] && wdata_r[FC_DMA];
      trig_r    <= wdata_r[FC_FIFO_EN] ? wdata_r[FC_TRIG +: 2] : trig_r;
      // a change of mode also flushes both fifos
      tx_rst_r  <= (wdata_r[FC_FIFO_EN] && wdata_r[FC_TX_RST])
                   || (wdata_r[FC_FIFO_EN] != fifo_en_r);
      rx_rst_r  <= (wdata_r[FC_FIFO_EN] && wdata_r[FC_RX_RST])
                   || (wdata_r[FC_FIFO_EN] != fifo_en_r);
    end
    else
    begin
      tx_rst_r <= 1'b0;
      rx_rst_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ier_r    <= IER_RST;
      div_r    <= DIV_RST;
      scr_r    <= SCR_RST;
      reload_r <= 1'b0;
    end
    else
    begin
      reload_r <= 1'b0;
      if (wr_ok && awaddr_r == OFF_DATA && divisor_access)
      begin
        div_r[7:0] <= wdata_r;
        reload_r   <= 1'b1;
      end
      if (wr_ok && awaddr_r == OFF_IER && divisor_access)
      begin
        div_r[15:8] <= wdata_r;
        reload_r    <= 1'b1;
      end
      if (wr_ok && awaddr_r == OFF_IER && !divisor_access)
      begin
        ier_r <= {4'h0, wdata_r[3:0]};
      end
      if (wr_ok && awaddr_r == OFF_SCRATCH)
      begin
        scr_r <= wdata_r;
      end
    end
  end

  always_comb
  begin
    case (trig_r)
      2'h0:    trig_lvl = TRIG_L0;
      2'h1:    trig_lvl = TRIG_L1;
      2'h2:    trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase
  end

  // idle timer restarts on any rx fifo access; counts 16x ticks while data waits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tout_cnt_r <= 10'h000;
    end
    else if (!fifo_en_r || rx_count == 5'h00 || rx_push || rx_read || rx_rst_r)
    begin
      tout_cnt_r <= 10'h000;
    end
    else if (tick_r && tout_cnt_r != TOUT_TICKS)
    begin
      tout_cnt_r <= tout_cnt_r + 10'h001;
    end
  end
  assign tout_hit = (tout_cnt_r == TOUT_TICKS);

  assign src_rls  = ier_r[IE_LS] && line_err;
  assign src_rda  = ier_r[IE_RX]
                    && (fifo_en_r ? (rx_count >= trig_lvl) : (rx_count != 5'h00));
  assign src_tout = ier_r[IE_RX] && fifo_en_r && tout_hit;
  assign src_thre = ier_r[IE_TX] && thre_r;
  assign src_ms   = ier_r[IE_HS] && modem_change;

  always_comb
  begin
    if (src_rls)
      id_code = ID_RLS;
    else if (src_rda)
      id_code = ID_RDA;
    else if (src_tout)
      id_code = ID_TOUT;
    else if (src_thre)
      id_code = ID_THRE;
    else if (src_ms)
      id_code = ID_MSR;
    else
      id_code = ID_NONE;
  end
  assign ident_val = {fifo_en_r, fifo_en_r, 2'h0, id_code};

  // tx empty is sticky; a new empty edge beats a clear in the same cycle
  assign thre_set = tx_empty && !tx_empty_d_r;
  assign thre_clr = tx_write || (ar_hs && s_axi_araddr == OFF_IDENT && id_code == ID_THRE);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      thre_r       <= 1'b0;
      tx_empty_d_r <= 1'b0;
    end
    else
    begin
      tx_empty_d_r <= tx_empty;
      thre_r       <= thre_set || (thre_r && !thre_clr);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_r  <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      irq_r  <= (id_code != ID_NONE);
      tick_r <= bif.tick16;
    end
  end

  always_comb
  begin
    rd_val = 8'h00;
    rd_err = 1'b0;
    case (s_axi_araddr)
      OFF_DATA:    rd_val = divisor_access ? div_r[7:0] : 8'h00;
      OFF_IER:     rd_val = divisor_access ? div_r[15:8] : ier_r;
      OFF_IDENT:   rd_val = ident_val;
      OFF_SCRATCH: rd_val = scr_r;
      default:     rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r  <= 1'b1;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= RESP_OKAY;
      rd_ident_r <= 1'b0;
      rd_ier_r   <= 1'b0;
    end
    else if (ar_hs)
    begin
      arready_r  <= 1'b0;
      rvalid_r   <= 1'b1;
      rdata_r    <= {24'h000000, rd_val};
      rresp_r    <= rd_err ? RESP_SLVERR : RESP_OKAY;
      rd_ident_r <= (s_axi_araddr == OFF_IDENT);
      rd_ier_r   <= (s_axi_araddr == OFF_IER) && !divisor_access;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tx_rst_pulse_a: assert property (tx_fifo_rst |=> !tx_fifo_rst)
    else $error("tx fifo reset held longer than one cycle");
  rx_rst_pulse_a: assert property (rx_fifo_rst |=> !rx_fifo_rst)
    else $error("rx fifo reset held longer than one cycle");
  ident_top_a: assert property ($rose(rvalid_r) && rd_ident_r
                                |-> rdata_r[7:6] == {2{$past(fifo_en_r)}})
    else $error("ident top bits do not follow fifo mode");
  ident_mid_a: assert property ($rose(rvalid_r) && rd_ident_r |-> rdata_r[5:4] == 2'h0)
    else $error("ident bits 5:4 not zero");
  ier_upper_a: assert property ($rose(rvalid_r) && rd_ier_r |-> rdata_r[7:4] == 4'h0)
    else $error("enable register upper nibble not zero");
  irq_off_a: assert property (ier_r[3:0] == 4'h0 |=> !irq_out)
    else $error("interrupt raised with all enables clear");
  dma_mode_a: assert property (dma_mode1 |-> fifo_mode)
    else $error("dma mode 1 outside fifo mode");
  rls_first_a: assert property (src_rls |=> irq_out ##0 $past(id_code) == ID_RLS)
    else $error("receive status not given first priority");
  thre_clear_a: assert property (tx_write && !thre_set |=> !thre_r)
    else $error("tx empty flag survived a transmit write");
  tout_code_a: assert property (src_tout && !src_rls && !src_rda
                                |-> id_code == ID_TOUT && ident_val[3:0] == 4'hC)
    else $error("timeout not reported");
  reload_tick_a: assert property (reload_r |=> ##1 !baud_tick16)
    else $error("baud tick right after divisor reload");

  write_seen_c: cover property (bvalid_r && s_axi_bready && bresp_r == RESP_OKAY);
  tout_seen_c:  cover property (src_tout ##1 rx_read);
  thre_read_c:  cover property (ar_hs && s_axi_araddr == OFF_IDENT && id_code == ID_THRE);
endmodule
`default_nettype wire

// ---- ufb_side_model.sv ----
// far-side model: receive fifo fill, line error, transmitter and modem flags
`timescale 1ns/1ps
`default_nettype none
module ufb_side_model (
  input  wire logic       aclk,
  output logic            line_err,
  output logic [4:0]      rx_count,
  output logic            rx_push,
  output logic            rx_read,
  output logic            tx_empty,
  output logic            tx_write,
  output logic            modem_change
);
  initial
  begin
    line_err = 1'b0;
    rx_count = 5'h00;
    rx_push = 1'b0;
    rx_read = 1'b0;
    tx_empty = 1'b0;
    tx_write = 1'b0;
    modem_change = 1'b0;
  end
  // one byte per two cycles; fill stays within 0..16 like the real fifo
  task automatic rx_move(input int n, input bit take);
    repeat (n)
    begin
      @(posedge aclk);
      if (take && rx_count > 5'h00)
      begin
        rx_count <= rx_count - 5'h01;
        rx_read <= 1'b1;
      end
      else if (!take && rx_count < 5'h10)
      begin
        rx_count <= rx_count + 5'h01;
        rx_push <= 1'b1;
      end
      @(posedge aclk);
      rx_push <= 1'b0;
      rx_read <= 1'b0;
    end
    repeat (2) @(posedge aclk);
  endtask
  // a host write to the transmit buffer always comes with the buffer turning non-empty
  task automatic tx_set(input bit empty);
    @(posedge aclk);
    tx_empty <= empty;
    tx_write <= !empty;
    @(posedge aclk);
    tx_write <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic flags(input bit err, input bit modem);
    @(posedge aclk);
    line_err <= err;
    modem_change <= modem;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- uart_fifo_irq_baud_core_tb.sv ----
// self-checking bench for the uart fifo, interrupt, baud and scratch core
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_irq_baud_core_tb;
  import ufb_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        divisor_access = 1'b0, high_speed = 1'b0;
  logic        line_err, rx_push, rx_read, tx_empty, tx_write, modem_change;
  logic [4:0]  rx_count;
  logic        fifo_mode, dma_mode1, tx_fifo_rst, rx_fifo_rst, baud_tick16, irq_out;
  logic [1:0]  rx_trig_sel;
  int          error_cnt = 0, total_checks = 0, cyc = 0, tx_rc = 0, rx_rc = 0;

  always #25 aclk = ~aclk;

  ufb_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .divisor_access(divisor_access),
    .high_speed(high_speed), .line_err(line_err), .rx_count(rx_count), .rx_push(rx_push),
    .rx_read(rx_read), .tx_empty(tx_empty), .tx_write(tx_write),
    .modem_change(modem_change), .fifo_mode(fifo_mode), .dma_mode1(dma_mode1),
    .rx_trig_sel(rx_trig_sel), .tx_fifo_rst(tx_fifo_rst), .rx_fifo_rst(rx_fifo_rst),
    .baud_tick16(baud_tick16), .irq_out(irq_out));

  ufb_side_model side (.aclk(aclk), .line_err(line_err), .rx_count(rx_count),
    .rx_push(rx_push), .rx_read(rx_read), .tx_empty(tx_empty), .tx_write(tx_write),
    .modem_change(modem_change));

  // counting high cycles proves each reset strobe is a single self-clearing cycle
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (tx_fifo_rst === 1'b1) tx_rc <= tx_rc + 1;
    if (rx_fifo_rst === 1'b1) rx_rc <= rx_rc + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic chk_num(input string nm, input int e, input int g);
    chk_word(nm, e, g);
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    // a fresh edge keeps the previous release and this request apart
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) aw = 0;
      if (w && s_axi_wready === 1'b1) w = 0;
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk_word(nm, {24'h000000, e}, d);
    chk_word("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  function automatic logic [7:0] id(input logic f, input logic [3:0] c);
    return {f, f, 2'b00, c};
  endfunction
  task automatic tick_gap(output int g);
    g = 0;
    @(posedge aclk);
    while (baud_tick16 !== 1'b1) @(posedge aclk);
    do
    begin
      @(posedge aclk);
      g++;
    end while (baud_tick16 !== 1'b1);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(OFF_IER, IER_RST, "enable reset");
    rd_chk(OFF_SCRATCH, SCR_RST, "scratch reset");
    rd_chk(OFF_IDENT, id(1'b0, ID_NONE), "ident reset");
    axi_read(5'h10, d, r);
    chk_word("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk_word("unmapped rdata", 32'h00000000, d);
    axi_write(5'h0C, 8'hFF, r);
    chk_word("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    divisor_access <= 1'b1;
    rd_chk(OFF_DATA, DIV_RST[7:0], "divisor low reset");
    rd_chk(OFF_IER, DIV_RST[15:8], "divisor high reset");
    divisor_access <= 1'b0;
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(OFF_SCRATCH, 8'hA5);
    rd_chk(OFF_SCRATCH, 8'hA5, "scratch");
    wr(OFF_SCRATCH, 8'h5A);
    rd_chk(OFF_SCRATCH, 8'h5A, "scratch");
    // lane 0 strobe off: write is answered but nothing is stored
    s_axi_wstrb <= 4'hE;
    wr(OFF_SCRATCH, 8'h33);
    s_axi_wstrb <= 4'hF;
    rd_chk(OFF_SCRATCH, 8'h5A, "scratch lane off");
    rd_chk(OFF_IDENT, id(1'b0, ID_NONE), "ident after scratch");
    wr(OFF_IER, 8'hFF);
    rd_chk(OFF_IER, 8'h0F, "enable upper bits");
    wr(OFF_IER, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_fifo();
    int t0;
    int r0;
    wr(OFF_IDENT, 8'h08);
    chk_bit("dma without fifo", 1'b0, dma_mode1);
    wr(OFF_IDENT, 8'h01);
    chk_bit("fifo mode", 1'b1, fifo_mode);
    wr(OFF_IDENT, 8'h09);
    chk_bit("dma mode1", 1'b1, dma_mode1);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_IDENT, {k[1:0], 6'h01});
      chk_word("trigger code", k, {30'h0, rx_trig_sel});
    end
    t0 = tx_rc;
    r0 = rx_rc;
    wr(OFF_IDENT, 8'h05);
    repeat (2) @(posedge aclk);
    chk_num("tx reset pulses", t0 + 1, tx_rc);
    chk_num("rx reset unmoved", r0, rx_rc);
    wr(OFF_IDENT, 8'h03);
    repeat (2) @(posedge aclk);
    chk_num("rx reset pulses", r0 + 1, rx_rc);
    chk_num("tx reset unmoved", t0 + 1, tx_rc);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "ident fifo mode");
    wr(OFF_IDENT, 8'h00);
    chk_bit("dma cleared", 1'b0, dma_mode1);
    rd_chk(OFF_IDENT, id(1'b0, ID_NONE), "ident 16450");
    $display("test fifo done");
  endtask

  task automatic t_irq();
    wr(OFF_IDENT, 8'h01);
    wr(OFF_IDENT, 8'h41);
    wr(OFF_IER, 8'h01);
    side.rx_move(3, 0);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "below trigger");
    side.rx_move(1, 0);
    rd_chk(OFF_IDENT, id(1'b1, ID_RDA), "at trigger");
    side.rx_move(1, 1);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "drained below");
    wr(OFF_IDENT, 8'h01);
    wr(OFF_IER, 8'h0F);
    side.tx_set(1'b1);
    side.flags(1'b1, 1'b1);
    rd_chk(OFF_IDENT, id(1'b1, ID_RLS), "line first");
    side.flags(1'b0, 1'b1);
    rd_chk(OFF_IDENT, id(1'b1, ID_RDA), "data second");
    side.rx_move(3, 1);
    rd_chk(OFF_IDENT, id(1'b1, ID_THRE), "tx third");
    rd_chk(OFF_IDENT, id(1'b1, ID_MSR), "modem fourth");
    chk_bit("irq pending", 1'b1, irq_out);
    side.flags(1'b0, 1'b0);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "all clear");
    chk_bit("irq idle", 1'b0, irq_out);
    side.tx_set(1'b0);
    side.tx_set(1'b1);
    chk_bit("irq tx", 1'b1, irq_out);
    side.tx_set(1'b0);
    chk_bit("irq tx written", 1'b0, irq_out);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "tx cleared by write");
    $display("test irq done");
  endtask

  task automatic t_mask();
    int          bits [4] = '{0, 2, 3, 1};
    logic [3:0]  codes [4];
    codes = '{ID_RDA, ID_RLS, ID_MSR, ID_THRE};
    wr(OFF_IER, 8'h00);
    side.rx_move(1, 0);
    side.tx_set(1'b1);
    side.flags(1'b1, 1'b1);
    chk_bit("irq all off", 1'b0, irq_out);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "ident all off");
    // tx enable goes last because reading its code clears it
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_IER, 8'h01 << bits[i]);
      repeat (3) @(posedge aclk);
      chk_bit("irq single enable", 1'b1, irq_out);
      rd_chk(OFF_IDENT, id(1'b1, codes[i]), "single enable");
    end
    wr(OFF_IER, 8'h00);
    side.flags(1'b0, 1'b0);
    side.rx_move(1, 1);
    $display("test mask done");
  endtask

  task automatic t_baud();
    int g;
    int n;
    wr(OFF_IER, 8'h05);
    divisor_access <= 1'b1;
    wr(OFF_IER, 8'h00);
    wr(OFF_DATA, 8'h03);
    tick_gap(g);
    tick_gap(g);
    chk_num("normal gap", PRE_DIV_INT * 3, g);
    high_speed <= 1'b1;
    tick_gap(g);
    tick_gap(g);
    chk_num("high speed gap", 3, g);
    wr(OFF_IER, 8'h10);
    wr(OFF_IER, 8'h00);
    n = 0;
    while (baud_tick16 !== 1'b1 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    chk_bit("reload on write", 1'b1, n <= 8);
    high_speed <= 1'b0;
    wr(OFF_DATA, 8'h01);
    divisor_access <= 1'b0;
    rd_chk(OFF_IER, 8'h05, "enable kept");
    $display("test baud done");
  endtask

  task automatic t_tout();
    wr(OFF_IDENT, 8'hC1);
    wr(OFF_IER, 8'h01);
    side.rx_move(2, 0);
    repeat (8100) @(posedge aclk);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "before timeout");
    repeat (400) @(posedge aclk);
    rd_chk(OFF_IDENT, id(1'b1, ID_TOUT), "timeout");
    side.rx_move(1, 1);
    rd_chk(OFF_IDENT, id(1'b1, ID_NONE), "timeout cleared");
    $display("test timeout done");
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_fifo();
    t_irq();
    t_mask();
    t_baud();
    t_tout();
    tally_and_finish();
  end
endmodule
`default_nettype wire
